// ---- pkg/seg_digit_consts.svh ----
`ifndef SEG_DIGIT_CONSTS_SVH
`define SEG_DIGIT_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define OFS_CTRL      8'h00
`define OFS_SERIAL    8'h04
`define OFS_STATUS    8'h08
`define OFS_SEGS      8'h0C

// ----------------------------------------
// Register fields and reset values
// ----------------------------------------
`define CTRL_HEX_BIT  0
`define CTRL_SER_BIT  1
`define SER_CODE_LSB  0
`define SER_DIG_LSB   4
`define STAT_PT_LSB   4
`define CTRL_RESET    2'h0
`define WORD_ZERO     32'h0000_0000

// ----------------------------------------
// Digit codes and display constants
// ----------------------------------------
`define NUM_DIGITS    4
`define CODE_ZERO     4'h0
`define CODE_PT_ON    4'hC
`define CODE_PT_OFF   4'hD
`define CODE_BLANK    4'hF
`define HOLD_RESET    4'h0
`define SEG_OFF       7'h00
`define PIN_WIDTH     13

`endif

// ---- pkg/seg_digit_pkg.sv ----
package seg_digit_pkg;
	typedef logic [3:0] code_t;
	typedef logic [6:0] seg_t;
	typedef enum logic {SRC_PARALLEL, SRC_SERIAL} source_e;
endpackage

// ---- pkg/glyph_if.sv ----
`timescale 1ns/1ps
`default_nettype none
interface glyph_if;
	import seg_digit_pkg::*;
	code_t code;
	logic  hex;
	logic  numeral_off;
	seg_t  segs;
	modport decoder (input code, input hex, input numeral_off, output segs);
	modport user (output code, output hex, output numeral_off, input segs);
endinterface
`default_nettype wire

// ---- logic/pin_sync.sv ----
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
	parameter int W = 1
) (
	input  wire logic         clk,    // Sampling clock
	input  wire logic         rst_n,  // Async reset, active low
	input  wire logic [W-1:0] d,      // Raw pins
	output logic      [W-1:0] q       // Synchronised pins
);
	logic [W-1:0] meta;

	// Two flops; idle is all high as with open pulled-up pins
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta <= '1;
			q    <= '1;
		end else begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule
`default_nettype wire

// ---- logic/glyph_decoder.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "seg_digit_consts.svh"
module glyph_decoder
	import seg_digit_pkg::*;
(
	glyph_if.decoder g  // Code in, segments out
);
	// Segment pattern gfedcba for a code in either variant
	function automatic seg_t glyph(input code_t c, input logic hex);
		seg_t s;
		s = `SEG_OFF;
		case (c)
			4'h0: s = 7'h3F;
			4'h1: s = 7'h06;
			4'h2: s = 7'h5B;
			4'h3: s = 7'h4F;
			4'h4: s = 7'h66;
			4'h5: s = 7'h6D;
			4'h6: s = 7'h7D;
			4'h7: s = 7'h07;
			4'h8: s = 7'h7F;
			4'h9: s = 7'h6F;
			4'hA: s = hex ? 7'h77 : 7'h40;
			4'hB: s = hex ? 7'h7C : `SEG_OFF;
			4'hC: s = hex ? 7'h39 : `SEG_OFF;
			4'hD: s = hex ? 7'h5E : `SEG_OFF;
			4'hE: s = hex ? 7'h79 : `SEG_OFF;
			4'hF: s = hex ? 7'h71 : `SEG_OFF;
			default: s = `SEG_OFF;
		endcase
		return s;
	endfunction

	// Blanking overrides the glyph
	always_comb begin
		g.segs = g.numeral_off ? `SEG_OFF : glyph(g.code, g.hex);
	end
endmodule
`default_nettype wire

// ---- logic/segment_digit_decoder.sv ----
// The register addresses and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
`include "seg_digit_consts.svh"
module segment_digit_decoder
	import seg_digit_pkg::*;
(
	input  wire logic        pclk,            // Clock, 200 MHz
	input  wire logic        presetn,         // Async reset, active low
	input  wire logic        psel,            // APB select
	input  wire logic        penable,         // APB enable
	input  wire logic        pwrite,          // APB write
	input  wire logic [7:0]  paddr,           // APB byte address
	input  wire logic [31:0] pwdata,          // APB write data
	output logic      [31:0] prdata,          // APB read data
	output logic             pready,          // APB ready
	output logic             pslverr,         // APB error
	input  wire logic [3:0]  data_n,          // Code bits, active low
	input  wire logic        digit1_hold_n,   // Digit 1 hold strobe
	input  wire logic        digit2_hold_n,   // Digit 2 hold strobe
	input  wire logic        digit3_hold_n,   // Digit 3 hold strobe
	input  wire logic        digit4_hold_n,   // Digit 4 hold strobe
	input  wire logic        point_on_n,      // Decimal point request
	input  wire logic        blank_in_n,      // Numeral blanking
	input  wire logic        red_sel_n,       // Red colour select
	input  wire logic        green_sel_n,     // Green colour select
	input  wire logic        zero_chain_in_n, // Chain into digit 4
	output logic [3:0][6:0]  segments,        // Segments per digit
	output logic [3:0]       point_lit,       // Decimal point per digit
	output logic [3:0]       zero_chain_out_n,// Chain out per digit
	output logic             red_on,          // Red elements lit
	output logic             green_on         // Green elements lit
);

	// ----------------------------------------
	// Input synchronisers
	// ----------------------------------------
	logic [`PIN_WIDTH-1:0] pins_raw;
	logic [`PIN_WIDTH-1:0] pins;
	code_t                 data_s;
	logic [3:0]            hold_s;
	logic                  point_s;
	logic                  blank_s;
	logic                  red_s;
	logic                  green_s;
	logic                  chain_s;

	// Bundle the pins; idle level is high
	assign pins_raw = {zero_chain_in_n, green_sel_n, red_sel_n, blank_in_n,
		point_on_n, digit4_hold_n, digit3_hold_n, digit2_hold_n,
		digit1_hold_n, data_n};

	pin_sync #(
		.W (`PIN_WIDTH)
	) u_sync (
		.clk   (pclk),
		.rst_n (presetn),
		.d     (pins_raw),
		.q     (pins)
	);

	// Invert to active-high meanings
	assign data_s  = ~pins[3:0];
	assign hold_s  = ~pins[7:4];
	assign point_s = ~pins[8];
	assign blank_s = ~pins[9];
	assign red_s   = ~pins[10];
	assign green_s = ~pins[11];
	assign chain_s = ~pins[12];

	// ----------------------------------------
	// APB slave
	// ----------------------------------------
	logic    hex_mode;
	source_e source;
	logic [5:0] serial_last;
	logic    access;
	logic    ser_wr;
	logic [3:0] chain_act;
	logic [3:0] point_act;
	seg_t    seg_next [`NUM_DIGITS];

	// Decode of mapped word addresses
	function automatic logic mapped(input logic [7:0] a);
		return (a == `OFS_CTRL) || (a == `OFS_SERIAL) ||
			(a == `OFS_STATUS) || (a == `OFS_SEGS);
	endfunction

	// Read data for a mapped address
	function automatic logic [31:0] rd_word(input logic [7:0] a);
		logic [31:0] w;
		w = `WORD_ZERO;
		case (a)
			`OFS_CTRL:   w[1:0] = {source == SRC_SERIAL, hex_mode};
			`OFS_SERIAL: w[5:0] = serial_last;
			`OFS_STATUS: w[7:0] = {point_lit, ~zero_chain_out_n};
			`OFS_SEGS:   w[27:0] = segments;
			default:     w = `WORD_ZERO;
		endcase
		return w;
	endfunction

	// One wait state: ready rises in the second access cycle
	assign access = psel && penable && !pready;
	assign ser_wr = access && pwrite && (paddr == `OFS_SERIAL);

	// Handshake and read answer
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= `WORD_ZERO;
		end else begin
			pready  <= access;
			pslverr <= access && !mapped(paddr);
			if (access && !pwrite) begin
				prdata <= rd_word(paddr);
			end else begin
				prdata <= `WORD_ZERO;
			end
		end
	end

	// Control register: variant and data source
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hex_mode <= 1'(`CTRL_RESET >> `CTRL_HEX_BIT);
			source   <= SRC_PARALLEL;
		end else if (access && pwrite && paddr == `OFS_CTRL) begin
			hex_mode <= pwdata[`CTRL_HEX_BIT];
			source   <= pwdata[`CTRL_SER_BIT] ? SRC_SERIAL : SRC_PARALLEL;
		end
	end

	// ----------------------------------------
	// Serial digit data
	// ----------------------------------------
	code_t      ser_code [`NUM_DIGITS];
	logic [3:0] ser_point;
	logic [3:0] ser_blank;
	code_t      wr_code;
	logic [1:0] wr_digit;

	assign wr_code  = pwdata[`SER_CODE_LSB +: 4];
	assign wr_digit = pwdata[`SER_DIG_LSB +: 2];

	// A serial frame updates only its addressed digit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			serial_last <= 6'h00;
			ser_point   <= 4'h0;
			ser_blank   <= 4'h0;
			for (int i = 0; i < `NUM_DIGITS; i++) begin
				ser_code[i] <= `HOLD_RESET;
			end
		end else if (ser_wr) begin
			serial_last <= pwdata[5:0];
			ser_code[wr_digit] <= wr_code;
			if (wr_code == `CODE_PT_ON) begin
				ser_point[wr_digit] <= 1'b1;
			end else if (wr_code == `CODE_PT_OFF) begin
				ser_point[wr_digit] <= 1'b0;
			end
			ser_blank[wr_digit] <= (wr_code == `CODE_BLANK);
		end
	end

	// ----------------------------------------
	// Parallel held codes
	// ----------------------------------------
	code_t held [`NUM_DIGITS];

	// Each digit follows the bus while its own strobe is inactive
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			for (int i = 0; i < `NUM_DIGITS; i++) begin
				held[i] <= `HOLD_RESET;
			end
		end else begin
			for (int i = 0; i < `NUM_DIGITS; i++) begin
				if (!hold_s[i]) begin
					held[i] <= data_s;
				end
			end
		end
	end

	// ----------------------------------------
	// Per-digit decode
	// ----------------------------------------
	code_t      code_sel [`NUM_DIGITS];
	logic [3:0] numeral_off;

	// Source choice; serial data bypasses the hold strobes
	always_comb begin
		for (int i = 0; i < `NUM_DIGITS; i++) begin
			code_sel[i] = (source == SRC_SERIAL) ? ser_code[i] : held[i];
		end
	end

	// Point: pin lights any digit, serial point on decimal only
	always_comb begin
		for (int i = 0; i < `NUM_DIGITS; i++) begin
			point_act[i] = point_s ||
				(source == SRC_SERIAL && !hex_mode && ser_point[i]);
		end
	end

	// Zero chain runs from digit 4 down to digit 1
	always_comb begin
		logic cin;
		cin = chain_s;
		for (int i = `NUM_DIGITS - 1; i >= 0; i--) begin
			chain_act[i] = cin && !blank_s && !point_act[i] &&
				(code_sel[i] == `CODE_ZERO);
			cin = chain_act[i];
		end
	end

	// Numeral blanking from pin, serial fifteen and zero chain
	always_comb begin
		for (int i = 0; i < `NUM_DIGITS; i++) begin
			numeral_off[i] = blank_s || chain_act[i] ||
				(source == SRC_SERIAL && ser_blank[i]);
		end
	end

	// Glyph decoders over the carrier interface
	for (genvar gi = 0; gi < `NUM_DIGITS; gi++) begin : g_digit
		glyph_if gl ();
		assign gl.code        = code_sel[gi];
		assign gl.hex         = hex_mode;
		assign gl.numeral_off = numeral_off[gi];
		assign seg_next[gi]   = gl.segs;
		glyph_decoder u_dec (
			.g (gl.decoder)
		);
	end

	// ----------------------------------------
	// Registered outputs
	// ----------------------------------------

	// Segment, point and chain outputs
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			segments         <= '0;
			point_lit        <= 4'h0;
			zero_chain_out_n <= 4'hF;
		end else begin
			for (int i = 0; i < `NUM_DIGITS; i++) begin
				segments[i] <= seg_next[i];
			end
			point_lit        <= point_act;
			zero_chain_out_n <= ~chain_act;
		end
	end

	// Colour selects; both together give orange
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			red_on   <= 1'b0;
			green_on <= 1'b0;
		end else begin
			red_on   <= red_s;
			green_on <= green_s;
		end
	end

endmodule
`default_nettype wire

// ---- tb/plc_outputs.sv ----
`timescale 1ns/1ps
`default_nettype none
module plc_outputs
	import seg_digit_pkg::*;
(
	input  wire logic  [3:0] code,   // True code to send
	input  wire logic  [3:0] hold,   // Hold request per digit
	input  wire logic        open,   // Outputs released
	output logic       [3:0] data_n, // Code pins
	output logic       [3:0] hold_n  // Hold pins
);
	// ----------------
	// Static outputs
	// ----------------
	// Released outputs float to the pull-up level, never the last value
	assign data_n = open ? 4'hF : ~code;
	assign hold_n = open ? 4'hF : ~hold;
endmodule
`default_nettype wire

// ---- tb/segment_digit_decoder_asserts.sv ----
`timescale 1ns/1ps
`default_nettype none
`include "seg_digit_consts.svh"
module segment_digit_decoder_asserts (
	input wire logic            pclk,             // Clock
	input wire logic            presetn,          // Reset, active low
	input wire logic            psel,             // Select
	input wire logic            penable,          // Enable
	input wire logic [31:0]     prdata,           // Read data
	input wire logic            pready,           // Ready
	input wire logic            pslverr,          // Error
	input wire logic            point_on_n,       // Point pin
	input wire logic            blank_in_n,       // Blank pin
	input wire logic            red_sel_n,        // Red pin
	input wire logic            green_sel_n,      // Green pin
	input wire logic [3:0][6:0] segments,         // Segments
	input wire logic [3:0]      point_lit,        // Points
	input wire logic [3:0]      zero_chain_out_n, // Chain out
	input wire logic            red_on,           // Red lit
	input wire logic            green_on          // Green lit
);
	// ----------------
	// Checks
	// ----------------
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	AST_BLANK: assert property (!blank_in_n [*6] |-> segments == 28'h0)
		else $error("blank pin left numerals lit");
	AST_POINT: assert property (!point_on_n [*5] |-> point_lit == 4'hF)
		else $error("point pin did not light points");
	AST_RED: assert property ($past(presetn, 3) |-> red_on == !$past(red_sel_n, 3))
		else $error("red output wrong");
	AST_GREEN: assert property ($stable(green_sel_n) [*6] |-> green_on == !green_sel_n)
		else $error("green output wrong");
	AST_ORANGE: assert property ((!red_sel_n && !green_sel_n) [*6] |-> red_on && green_on)
		else $error("orange not shown");
	AST_CHAIN: assert property (!zero_chain_out_n[3] |-> segments[3] == `SEG_OFF)
		else $error("suppressed digit still lit");
	AST_PRDY: assert property (psel && !penable ##1 psel && penable |=> pready)
		else $error("ready late");
	AST_PULSE: assert property (pready |=> !pready)
		else $error("ready too long");
	AST_IDLE: assert property (!pready |-> prdata == `WORD_ZERO)
		else $error("read data outside answer");
	AST_ERR: assert property (pslverr |-> pready)
		else $error("error without ready");
endmodule
bind segment_digit_decoder segment_digit_decoder_asserts i_chk (.pclk, .presetn, .psel,
	.penable, .prdata, .pready, .pslverr, .point_on_n, .blank_in_n, .red_sel_n,
	.green_sel_n, .segments, .point_lit, .zero_chain_out_n, .red_on, .green_on);
`default_nettype wire

// ---- tb/segment_digit_decoder_bench.sv ----
`timescale 1ns/1ps
`default_nettype none
module segment_digit_decoder_bench;
	logic            pclk = 1'b0;
	logic            presetn, psel, penable, pwrite, pready, pslverr, er, open;
	logic [7:0]      paddr;
	logic [31:0]     pwdata, prdata, rd;
	logic [3:0]      code, hold, data_n, hold_n, point_lit, zero_chain_out_n;
	logic            point_on_n, blank_in_n, red_sel_n, green_sel_n, zero_chain_in_n;
	logic [3:0][6:0] segments;
	logic            red_on, green_on;
	int              n_fail = 0, total_checks = 0, held[4], d, a, b, c, hx;
	// 200 MHz clock
	always #2.5 pclk = ~pclk;
	plc_outputs i_plc_outputs (.code(code), .hold(hold), .open(open), .data_n(data_n),
		.hold_n(hold_n));
	segment_digit_decoder i_segment_digit_decoder (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .data_n(data_n),
		.digit1_hold_n(hold_n[0]), .digit2_hold_n(hold_n[1]), .digit3_hold_n(hold_n[2]),
		.digit4_hold_n(hold_n[3]), .point_on_n(point_on_n), .blank_in_n(blank_in_n),
		.red_sel_n(red_sel_n), .green_sel_n(green_sel_n), .zero_chain_in_n(zero_chain_in_n),
		.segments(segments), .point_lit(point_lit), .zero_chain_out_n(zero_chain_out_n),
		.red_on(red_on), .green_on(green_on));
	// ----------------
	// Model and helpers
	// ----------------
	function automatic logic [31:0] segs_of(int h);
		logic [6:0]  t [16] = '{7'h3F, 7'h06, 7'h5B, 7'h4F, 7'h66, 7'h6D, 7'h7D, 7'h07,
			7'h7F, 7'h6F, 7'h77, 7'h7C, 7'h39, 7'h5E, 7'h79, 7'h71};
		logic [31:0] r = 32'h0;
		for (int k = 0; k < 4; k++)
			r[k*7 +: 7] = (h || held[k] < 10) ? t[held[k]] : (held[k] == 10) ? 7'h40 : 7'h00;
		return r;
	endfunction
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wt(int n);
		repeat (n) @(posedge pclk);
	endtask
	task automatic test_done;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
		int n = 0;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			n_fail++;
			test_done;
		end
	endtask
	// ----------------
	// Main sequence
	// ----------------
	initial begin
		{presetn, psel, penable, pwrite, paddr, pwdata, code, hold, open} = '0;
		{point_on_n, blank_in_n, red_sel_n, green_sel_n, zero_chain_in_n} = 5'h1F;
		held = '{0, 0, 0, 0};
		a = $urandom(32'h2E06474E);
		wt(8);
		presetn <= 1'b1;
		wt(6);
		chk({4'h0, segments}, segs_of(0));
		chk({28'h0, zero_chain_out_n}, 32'hF);
		apb(1'b0, 8'h0C, 32'h0);
		chk(rd, segs_of(0));
		$display("reset test done");
		for (hx = 0; hx < 2; hx++) begin
			apb(1'b1, 8'h00, 32'(hx));
			for (c = 0; c < 16; c++) begin
				code <= 4'(c);
				wt(6);
				held = '{c, c, c, c};
				chk({4'h0, segments}, segs_of(hx));
				chk({28'h0, point_lit}, 32'h0);
			end
		end
		open <= 1'b1;
		wt(6);
		held = '{0, 0, 0, 0};
		chk({4'h0, segments}, segs_of(1));
		open <= 1'b0;
		$display("code test done");
		// Hold one random digit while the code moves on
		apb(1'b1, 8'h00, 32'h0);
		d = $urandom % 4;
		a = $urandom % 10;
		b = $urandom % 10;
		code <= 4'(a);
		wt(6);
		hold[d] <= 1'b1;
		wt(6);
		code <= 4'(b);
		point_on_n <= 1'b0;
		wt(6);
		held = '{b, b, b, b};
		held[d] = a;
		chk({4'h0, segments}, segs_of(0));
		chk({28'h0, point_lit}, 32'hF);
		point_on_n <= 1'b1;
		$display("hold test done");
		// Serial frames with all hold strobes low
		apb(1'b1, 8'h00, 32'h2);
		hold <= 4'hF;
		for (d = 0; d < 4; d++) begin
			held[d] = $urandom % 10;
			apb(1'b1, 8'h04, 32'(d * 16 + held[d]));
		end
		wt(4);
		chk({4'h0, segments}, segs_of(0));
		for (c = 12; c < 16; c += (c == 13) ? 2 : 1) begin
			held[1] = c;
			apb(1'b1, 8'h04, 32'(16 + c));
			wt(4);
			chk({4'h0, segments}, segs_of(0));
			chk({28'h0, point_lit}, (c == 12) ? 32'h2 : 32'h0);
		end
		apb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h1F);
		apb(1'b0, 8'h10, 32'h0);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h0);
		apb(1'b1, 8'h01, 32'h3);
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h2);
		// Serial fifteen must also blank a hex digit
		apb(1'b1, 8'h00, 32'h3);
		wt(4);
		chk({4'h0, segments}, segs_of(1) & ~32'h0000_3F80);
		$display("serial test done");
		// Blanking, then zero suppression
		apb(1'b1, 8'h00, 32'h0);
		hold <= 4'h0;
		code <= 4'h8;
		blank_in_n <= 1'b0;
		point_on_n <= 1'b0;
		wt(6);
		chk({4'h0, segments}, 32'h0);
		apb(1'b0, 8'h08, 32'h0);
		chk(rd, 32'hF0);
		// Chain input fed only from the upstream side
		blank_in_n <= 1'b1;
		point_on_n <= 1'b1;
		code <= 4'h0;
		zero_chain_in_n <= 1'b0;
		wt(10);
		chk({4'h0, segments}, 32'h0);
		chk({28'h0, zero_chain_out_n}, 32'h0);
		point_on_n <= 1'b0;
		wt(10);
		held = '{0, 0, 0, 0};
		chk({4'h0, segments}, segs_of(0));
		chk({28'h0, zero_chain_out_n}, 32'hF);
		$display("blank test done");
		for (c = 0; c < 4; c++) begin
			{red_sel_n, green_sel_n} <= 2'(c);
			wt(6);
			chk({30'h0, red_on, green_on}, 32'(~c & 3));
		end
		$display("colour test done");
		test_done;
	end
endmodule
`default_nettype wire
